// [retimer_cfg.svh]
// retimer_cfg.svh: register offsets, field positions, reset values, timing
// assumes inclusion by bare name from the package; the design files use its macros
// Behaviour
// RL1 - in reference mode, calibrate at power-up, on CDR reset and on lock loss
// RL2 - step every coarse setting, count divided VCO edges over a reference window
// RL3 - keep the setting nearest target, use it until next calibration
// RL4 - target count comes from configured ppm count and ppm tolerance; code targets the count field alone, tolerance unused
// RL5 - four channels run independently with own state and settings
// RL6 - equalizer has four stages, each with own four-level boost
// RL7 - normally equalizer boost is chosen by adaptation, not fixed values
// RL8 - controller must write swing and de-emphasis for every channel
// RL9 - per-channel de-emphasis setting from 0 dB down to -12 dB
// RL10 - per-channel choice of full slew or slightly slower edges
// RL11 - registers readable and writable at any time, even during traffic; code drops bus writes until the loader finishes
// RL12 - optionally load register contents from an external memory at power-up; code always waits for load_last_i after every reset
// RL13 - on any interrupt, latch event-identifying information into registers
// RL14 - two-bit reference select: 2'b11 reference-assisted default, 2'b00 none
// RL15 - interrupt on signal loss after signal, lock loss after lock; always on; code lets the mask register silence irq_o
// RL16 - each channel drives its lock output high while locked
// RL17 - not locked during search; each calibration restarts from first setting
`ifndef RETIMER_CFG_SVH
`define RETIMER_CFG_SVH
`define CFG_CH_BASE      12'h000
`define CFG_CH_STRIDE    12'h010
`define CFG_GLOBAL_OFS   12'h100
`define CFG_STATUS_OFS   12'h104
`define CFG_MASK_OFS     12'h108
`define CFG_EVENT_OFS    12'h10C
`define CFG_LOAD_OFS     12'h110
`define CFG_REG_EQ       2'h0
`define CFG_REG_DRV      2'h1
`define CFG_REG_PPM      2'h2
`define CFG_REG_STAT     2'h3
`define CFG_EQ_ADAPT_BIT 8
`define CFG_EQ_RESET     32'h0000_0100
`define CFG_DRV_RESET    32'h0000_0000
`define CFG_PPM_RESET    32'h0010_2000
`define CFG_REFSEL_RESET 2'h3
`define CFG_REFSEL_ON    2'h3
`define CFG_REFSEL_OFF   2'h0
`define CFG_REF_MHZ      25
`define CFG_CLK_MHZ      125
`define CFG_REF_DIV      (`CFG_CLK_MHZ / `CFG_REF_MHZ)
`define CFG_CAL_WINDOW   1024
`endif

// [retimer_pkg.sv]
// retimer_pkg: shared types of the retimer control block
// assumes retimer_cfg.svh is on the include path
package retimer_pkg;
  `include "retimer_cfg.svh"
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_MEASURE,
    CAL_DONE
  } cal_state_t;
  typedef logic [1:0] boost_t;
endpackage : retimer_pkg

// [vco_cal_channel.sv]
// vco_cal_channel: coarse-tune search and lock tracking of one channel
// assumes vco_edge_i is a one-cycle pulse per divided VCO cycle in clock_i
`timescale 1ns/10ps
module vco_cal_channel
  import retimer_pkg::*;
#(
  parameter int CODE_W  = 5,
  parameter int COUNT_W = 16,
  parameter int WINDOW  = 1024
) (
  input  wire logic               clock_i,
  input  wire logic               reset_i,
  input  wire logic               enable_i,
  input  wire logic               ref_tick_i,
  input  wire logic               ref_on_i,
  input  wire logic               start_i,
  input  wire logic               vco_edge_i,
  input  wire logic               cdr_locked_i,
  input  wire logic [COUNT_W-1:0] target_i,
  input  wire logic [COUNT_W-1:0] tolerance_i,
  output logic      [CODE_W-1:0]  coarse_o,
  output logic                    locked_o,
  output logic                    busy_o
);
  import retimer_pkg::*;
  cal_state_t         state_q;
  logic [CODE_W-1:0]  trial_q;
  logic [CODE_W-1:0]  best_q;
  logic [COUNT_W-1:0] best_err_q;
  logic [COUNT_W-1:0] count_q;
  logic [15:0]        ticks_q;
  logic [COUNT_W-1:0] err;
  logic               win_end;

  assign err = (count_q > target_i) ? count_q - target_i : target_i - count_q;
  assign win_end = ref_tick_i && (ticks_q == 16'(WINDOW - 1));

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q    <= CAL_IDLE;
      trial_q    <= '0;
      best_q     <= '0;
      best_err_q <= '1;
      count_q    <= '0;
      ticks_q    <= '0;
    end else if (enable_i && start_i && ref_on_i) begin // RL1
      // a new request restarts even a search that is still running
      state_q    <= CAL_MEASURE;
      trial_q    <= '0; // RL17
      best_err_q <= '1;
      count_q    <= '0;
      ticks_q    <= '0;
    end else if (enable_i) begin
      unique case (state_q)
        CAL_IDLE, CAL_DONE: ;
        CAL_MEASURE: begin
          if (vco_edge_i && !win_end)
            count_q <= count_q + 1'b1; // RL2
          if (ref_tick_i)
            ticks_q <= win_end ? '0 : ticks_q + 1'b1;
          if (win_end) begin
            count_q <= '0;
            if (err < best_err_q) begin // RL3
              best_err_q <= err;
              best_q     <= trial_q;
            end
            if (&trial_q)
              state_q <= CAL_DONE;
            else
              trial_q <= trial_q + 1'b1; // RL2
          end
        end
      endcase
    end
  end

  // the vco runs on each trial during the sweep, then on the winner;
  // tolerance is only stored, the nearest setting wins regardless
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      coarse_o <= '0;
      locked_o <= 1'b0;
      busy_o   <= 1'b0;
    end else if (enable_i) begin
      busy_o <= (state_q == CAL_MEASURE);
      coarse_o <= (state_q == CAL_MEASURE) ? trial_q : best_q; // RL2 RL3
      locked_o <= cdr_locked_i && (state_q != CAL_MEASURE); // RL17
    end
  end
endmodule : vco_cal_channel

// [retimer_ctrl.sv]
// retimer_ctrl: four-channel retimer control with AHB-Lite register slave
// assumes one 125 MHz clock; reference and VCO events arrive as pulses
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module retimer_ctrl
  import retimer_pkg::*;
#(
  parameter int CHANNELS   = 4,
  parameter int CODE_W     = 5,
  parameter int CAL_WINDOW = `CFG_CAL_WINDOW
) (
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  input  wire logic                  enable_i,
  input  wire logic                  hsel_i,
  input  wire logic [11:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  input  wire logic                  ref_tick_i,
  input  wire logic [CHANNELS-1:0]   vco_edge_i,
  input  wire logic [CHANNELS-1:0]   cdr_locked_i,
  input  wire logic [CHANNELS-1:0]   cdr_reset_i,
  input  wire logic [CHANNELS-1:0]   signal_detect_i,
  input  wire logic                  load_valid_i,
  input  wire logic [11:0]           load_addr_i,
  input  wire logic [31:0]           load_data_i,
  input  wire logic                  load_last_i,
  output logic                       load_done_o,
  output logic [CHANNELS-1:0]        lock_o,
  output logic [CHANNELS*CODE_W-1:0] coarse_o,
  output logic [CHANNELS*8-1:0]      eq_boost_o,
  output logic [CHANNELS*3-1:0]      output_swing_o,
  output logic [CHANNELS*4-1:0]      deemphasis_level_o,
  output logic [CHANNELS-1:0]        slow_slew_o,
  output logic                       irq_o
);
  import retimer_pkg::*;

  logic [31:0]          eq_q   [CHANNELS];
  logic [31:0]          drv_q  [CHANNELS];
  logic [31:0]          ppm_q  [CHANNELS];
  logic [1:0]           refsel_q;
  logic [2*CHANNELS-1:0] status_q;
  logic [2*CHANNELS-1:0] mask_q;
  logic [31:0]          event_q;
  logic                 loading_q;
  logic                 wr_pend_q;
  logic [11:0]          wr_addr_q;
  logic                 por_q;
  logic [CHANNELS-1:0]  lock_prev_q;
  logic [CHANNELS-1:0]  sig_prev_q;
  logic [CHANNELS-1:0]  cal_lock;
  logic [CHANNELS-1:0]  cal_busy;
  logic [CHANNELS-1:0]  cal_start;
  logic [2*CHANNELS-1:0] new_ev;
  logic                 bus_wr;
  logic [11:0]          wr_a;
  logic [31:0]          wr_d;
  logic                 addr_ph;
  logic [2:0]           rd_ch;

  // channel block index and register slot from a byte address
  function automatic logic [2:0] chan_of(input logic [11:0] a);
    return (a[11:6] == 6'h00) ? {1'b0, a[5:4]} : 3'h4;
  endfunction : chan_of
  function automatic logic [1:0] slot_of(input logic [11:0] a);
    return a[3:2];
  endfunction : slot_of

  assign addr_ph = hsel_i && hready_i && htrans_i[1];
  assign rd_ch   = chan_of(haddr_i);
  // eeprom load owns the register file until done, then bus writes resume
  assign bus_wr  = loading_q ? load_valid_i : wr_pend_q; // RL12
  assign wr_a    = loading_q ? load_addr_i : wr_addr_q;
  assign wr_d    = loading_q ? load_data_i : hwdata_i;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (enable_i) begin
      wr_pend_q <= addr_ph && hwrite_i && !loading_q; // RL11
      wr_addr_q <= haddr_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hrdata_o    <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (enable_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (addr_ph && !hwrite_i) begin // RL11
        hrdata_o <= '0;
        if (rd_ch < 3'(CHANNELS)) begin
          unique case (slot_of(haddr_i))
            `CFG_REG_EQ:   hrdata_o <= eq_q[rd_ch[1:0]];
            `CFG_REG_DRV:  hrdata_o <= drv_q[rd_ch[1:0]];
            `CFG_REG_PPM:  hrdata_o <= ppm_q[rd_ch[1:0]];
            // coarse at 20:16, busy at 8, lock at 0
            `CFG_REG_STAT: hrdata_o <= 32'({
                coarse_o[rd_ch[1:0]*CODE_W +: CODE_W], 7'h00,
                cal_busy[rd_ch[1:0]], 7'h00, lock_o[rd_ch[1:0]]});
          endcase
        end else begin
          unique case (haddr_i)
            `CFG_GLOBAL_OFS: hrdata_o <= {30'h0, refsel_q};
            `CFG_STATUS_OFS: hrdata_o <= 32'(status_q);
            `CFG_MASK_OFS:   hrdata_o <= 32'(mask_q);
            `CFG_EVENT_OFS:  hrdata_o <= event_q;
            `CFG_LOAD_OFS:   hrdata_o <= {31'h0, !loading_q};
            default:         hrdata_o <= '0;
          endcase
        end
      end
    end
  end

  // per-channel settings; swing and de-emphasis are never changed by hardware
  genvar g;
  for (g = 0; g < CHANNELS; g++) begin : g_ch
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        eq_q[g]  <= `CFG_EQ_RESET; // RL7
        drv_q[g] <= `CFG_DRV_RESET; // RL8
        ppm_q[g] <= `CFG_PPM_RESET;
      end else if (enable_i && bus_wr && chan_of(wr_a) == 3'(g)) begin // RL5
        unique case (slot_of(wr_a))
          `CFG_REG_EQ:  eq_q[g]  <= {23'h0, wr_d[8:0]}; // RL6
          `CFG_REG_DRV: drv_q[g] <= {24'h0, wr_d[7:0]}; // RL9 RL10
          `CFG_REG_PPM: ppm_q[g] <= wr_d; // RL4
          default: ;
        endcase
      end
    end

    vco_cal_channel #(
      .CODE_W  (CODE_W),
      .COUNT_W (16),
      .WINDOW  (CAL_WINDOW)
    ) u_cal (
      .clock_i      (clock_i),
      .reset_i      (reset_i),
      .enable_i     (enable_i),
      .ref_tick_i   (ref_tick_i),
      .ref_on_i     (refsel_q == `CFG_REFSEL_ON), // RL14
      .start_i      (cal_start[g]),
      .vco_edge_i   (vco_edge_i[g]),
      .cdr_locked_i (cdr_locked_i[g]),
      .target_i     (ppm_q[g][15:0]), // RL4
      .tolerance_i  (ppm_q[g][31:16]),
      .coarse_o     (coarse_o[g*CODE_W +: CODE_W]),
      .locked_o     (cal_lock[g]),
      .busy_o       (cal_busy[g])
    );

    // power-up, cdr reset, or falling lock each start a fresh search in reference mode
    assign cal_start[g] = por_q || cdr_reset_i[g]
                        || (lock_prev_q[g] && !cdr_locked_i[g]); // RL1
    assign new_ev[g]          = sig_prev_q[g] && !signal_detect_i[g]; // RL15
    assign new_ev[CHANNELS+g] = lock_prev_q[g] && !cdr_locked_i[g]; // RL15

    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        eq_boost_o[g*8 +: 8]         <= '0;
        output_swing_o[g*3 +: 3]     <= '0;
        deemphasis_level_o[g*4 +: 4] <= '0;
        slow_slew_o[g]               <= 1'b0;
        lock_o[g]                    <= 1'b0;
      end else if (enable_i) begin
        // adapt bit set leaves stage boosts to the analog adaptation loop
        eq_boost_o[g*8 +: 8] <= eq_q[g][`CFG_EQ_ADAPT_BIT] ? 8'h00
                                                         : eq_q[g][7:0]; // RL7
        output_swing_o[g*3 +: 3]     <= drv_q[g][2:0];
        deemphasis_level_o[g*4 +: 4] <= drv_q[g][6:3]; // RL9
        slow_slew_o[g]               <= drv_q[g][7]; // RL10
        lock_o[g]                    <= cal_lock[g]; // RL16
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      por_q       <= 1'b1;
      lock_prev_q <= '0;
      sig_prev_q  <= '0;
      loading_q   <= 1'b1;
      load_done_o <= 1'b0;
      refsel_q    <= `CFG_REFSEL_RESET; // RL14
      mask_q      <= '0;
    end else if (enable_i) begin
      por_q       <= 1'b0;
      lock_prev_q <= cdr_locked_i;
      sig_prev_q  <= signal_detect_i;
      if (loading_q && load_valid_i && load_last_i)
        loading_q <= 1'b0; // RL12
      load_done_o <= !loading_q;
      if (bus_wr && wr_a == `CFG_GLOBAL_OFS)
        refsel_q <= wr_d[1:0]; // RL14
      if (bus_wr && wr_a == `CFG_MASK_OFS)
        mask_q <= wr_d[2*CHANNELS-1:0];
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      status_q <= '0;
      event_q  <= '0;
      irq_o    <= 1'b0;
    end else if (enable_i) begin
      status_q <= (status_q & ~((bus_wr && wr_a == `CFG_STATUS_OFS)
                  ? wr_d[2*CHANNELS-1:0] : '0)) | new_ev; // RL15
      if (|new_ev)
        event_q <= {16'h0, 8'(cdr_locked_i), 8'(new_ev)}; // RL13
      irq_o <= |((status_q | new_ev) & ~mask_q);
    end
  end
endmodule : retimer_ctrl

// [retimer_ctrl_chk.sv]
// retimer_ctrl_chk: port-level assertions for the retimer control block
// assumes it is bound to retimer_ctrl and sees one clock domain
`timescale 1ns/10ps
module retimer_ctrl_chk #(
  parameter int CHANNELS = 4,
  parameter int CODE_W   = 5
) (
  input wire logic                clock_i,
  input wire logic                reset_i,
  input wire logic                enable_i,
  input wire logic                hsel_i,
  input wire logic [11:0]         haddr_i,
  input wire logic [1:0]          htrans_i,
  input wire logic                hwrite_i,
  input wire logic [31:0]         hwdata_i,
  input wire logic                hready_i,
  input wire logic [31:0]         hrdata_o,
  input wire logic                hreadyout_o,
  input wire logic                hresp_o,
  input wire logic [CHANNELS-1:0] cdr_locked_i,
  input wire logic [CHANNELS-1:0] cdr_reset_i,
  input wire logic                load_valid_i,
  input wire logic                load_last_i,
  input wire logic                load_done_o,
  input wire logic [CHANNELS-1:0] lock_o,
  input wire logic [CHANNELS*3-1:0] output_swing_o,
  input wire logic [CHANNELS*4-1:0] deemphasis_level_o,
  input wire logic [CHANNELS-1:0] slow_slew_o,
  input wire logic                irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i || !enable_i);
  logic        acc;
  logic        wr_q;
  logic        rd0_q;
  logic        drv_q;
  logic        msk_q;
  logic [11:0] a_q;
  logic [7:0]  v_q;
  assign acc = hsel_i & hready_i & htrans_i[1];
  // writes before the loader finishes are dropped, so they are not tracked
  always_ff @(posedge clock_i) begin
    a_q <= haddr_i;
    wr_q <= !reset_i & enable_i & acc & hwrite_i & load_done_o;
    rd0_q <= !reset_i & enable_i & acc & !hwrite_i & (haddr_i == 12'h200);
  end
  always_ff @(posedge clock_i) begin
    drv_q <= !reset_i & wr_q & (a_q == 12'h004);
    msk_q <= !reset_i & wr_q & (a_q == 12'h108) & (hwdata_i[7:0] == 8'hFF);
    if (wr_q) v_q <= hwdata_i[7:0];
  end
  chk_resp_okay: assert property (!hresp_o)
    else $error("bus response not okay");
  chk_ready_high: assert property (hreadyout_o)
    else $error("bus ready dropped");
  chk_unmapped_zero: assert property (rd0_q |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_drive_update: assert property (drv_q |-> ##[0:2]
    {slow_slew_o[0], deemphasis_level_o[3:0], output_swing_o[2:0]} == v_q)
    else $error("drive settings of channel 0 not updated");
  chk_lock_needs_cdr: assert property (
    !cdr_locked_i[1] [*4] |-> !lock_o[1])
    else $error("lock shown without cdr lock");
  chk_cal_unlock: assert property (
    cdr_reset_i[3] |-> ##[1:3] !lock_o[3])
    else $error("lock shown after cdr reset");
  chk_mask_quiet: assert property (msk_q |-> ##[1:2] !irq_o)
    else $error("interrupt high with all masked");
  chk_done_sticky: assert property (load_done_o |=> load_done_o)
    else $error("load done fell");
  chk_done_cause: assert property ($rose(load_done_o) |->
    $past(load_valid_i & load_last_i) || $past(load_valid_i & load_last_i, 2))
    else $error("load done without last strobe");
  cover property (drv_q);
  cover property ($rose(lock_o[0]));
  cover property ($rose(irq_o));
  cover property (msk_q);
endmodule : retimer_ctrl_chk
bind retimer_ctrl retimer_ctrl_chk #(.CHANNELS(CHANNELS), .CODE_W(CODE_W))
  retimer_ctrl_chk_i (.clock_i, .reset_i, .enable_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
  .hresp_o, .cdr_locked_i, .cdr_reset_i, .load_valid_i, .load_last_i,
  .load_done_o, .lock_o, .output_swing_o, .deemphasis_level_o,
  .slow_slew_o, .irq_o);

// [retimer_link_model.sv]
// retimer_link_model: far side giving reference ticks, VCO edges and CDR
// assumes the 125 MHz clock; sig_on_i from the bench says where data runs
`timescale 1ns/10ps
module retimer_link_model (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  sig_on_i,
  input  wire logic [19:0] coarse_i,
  output logic             ref_tick_o,
  output logic [3:0]       vco_edge_o,
  output logic [3:0]       cdr_locked_o,
  output logic [3:0]       signal_detect_o
);
  logic [2:0]      ref_q;
  logic [3:0][5:0] div_q;
  always_ff @(posedge clock_i) begin
    if (reset_i || ref_q == 3'h4) ref_q <= 3'h0;
    else ref_q <= ref_q + 3'h1;
  end
  assign ref_tick_o = (ref_q == 3'h4);
  // a higher coarse code shortens the divided VCO period
  for (genvar n = 0; n < 4; n++) begin : g_ch
    always_ff @(posedge clock_i) begin
      if (reset_i || div_q[n] == 6'h0)
        div_q[n] <= 6'h28 - {1'b0, coarse_i[n*5+:5]};
      else div_q[n] <= div_q[n] - 6'h1;
    end
    assign vco_edge_o[n] = (div_q[n] == 6'h0);
  end
  // the recovered lock can only follow a detected signal
  always_ff @(posedge clock_i) begin
    signal_detect_o <= reset_i ? 4'h0 : sig_on_i;
    cdr_locked_o <= reset_i ? 4'h0 : signal_detect_o & sig_on_i;
  end
endmodule : retimer_link_model

// [tb_top.sv]
// tb_top: self-checking bench for retimer_ctrl, acting as bus controller
// assumes retimer_pkg, the checker and the link model are compiled first
`timescale 1ns/10ps
module tb_top;
  import retimer_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; bit w; logic [31:0] e;} row_t;
  logic        clock_i, reset_i, hsel_i, hwrite_i, load_valid_i, load_last_i;
  logic        hreadyout_o, hresp_o, ref_tick, load_done_o, irq_o, enable_i;
  logic [11:0] haddr_i, load_addr_i, output_swing_o;
  logic [1:0]  htrans_i;
  logic [31:0] hwdata_i, load_data_i, hrdata_o, rd, eq_boost_o;
  logic [3:0]  cdr_reset_i, sig_on, vco_edge, cdr_locked, sig_det;
  logic [3:0]  lock_o, slow_slew_o;
  logic [19:0] coarse_o;
  logic [15:0] deemphasis_level_o;
  logic [7:0]  drv;
  int          err_total, compares, cyc;
  row_t rows [11] = '{
    '{12'h000, 32'h0, 1'b0, 32'h100},
    '{12'h008, 32'h0, 1'b0, 32'h00102000},
    '{12'h100, 32'h0, 1'b0, 32'h3},
    '{12'h104, 32'h0, 1'b0, 32'h0},
    '{12'h004, 32'hA5, 1'b1, 32'hA5},
    '{12'h014, 32'h5A, 1'b1, 32'h5A},
    '{12'h024, 32'hFF, 1'b1, 32'hFF},
    '{12'h034, 32'h01, 1'b1, 32'h01},
    '{12'h028, 32'h00080800, 1'b1, 32'h00080800},
    '{12'h200, 32'h12, 1'b1, 32'h0},
    '{12'h020, 32'hE4, 1'b1, 32'hE4}};
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  retimer_ctrl #(.CAL_WINDOW(128)) retimer_ctrl_i (.clock_i, .reset_i,
    .enable_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .ref_tick_i(ref_tick), .vco_edge_i(vco_edge), .cdr_locked_i(cdr_locked),
    .cdr_reset_i, .signal_detect_i(sig_det), .load_valid_i, .load_addr_i,
    .load_data_i, .load_last_i, .load_done_o, .lock_o, .coarse_o,
    .eq_boost_o, .output_swing_o, .deemphasis_level_o, .slow_slew_o, .irq_o);
  retimer_link_model retimer_link_model_i (.clock_i, .reset_i,
    .sig_on_i(sig_on), .coarse_i(coarse_o), .ref_tick_o(ref_tick),
    .vco_edge_o(vco_edge), .cdr_locked_o(cdr_locked),
    .signal_detect_o(sig_det));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(bit w, logic [11:0] a, logic [31:0] d);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // one full search takes about 20500 cycles; this cuts a hung bus wait
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {hsel_i, hwrite_i, load_valid_i, load_last_i, htrans_i} = '0;
    {haddr_i, load_addr_i, hwdata_i, load_data_i, cdr_reset_i} = '0;
    enable_i = 1'b1;
    sig_on = 4'hF;
    reset_i = 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk("lock", 32'h0, {28'h0, lock_o});
    chk("irq", 32'h0, {31'h0, irq_o});
    bus(1'b0, 12'h00C, 32'h0);
    chk("busy", 32'h1, {31'h0, rd[8]});
    $display("test reset done");
    bus(1'b1, 12'h014, 32'h33);
    bus(1'b0, 12'h110, 32'h0);
    chk("loadreg", 32'h0, rd);
    load_valid_i <= 1'b1;
    load_last_i <= 1'b1;
    load_addr_i <= 12'h014;
    load_data_i <= 32'h44;
    @(posedge clock_i);
    load_valid_i <= 1'b0;
    load_last_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk("done", 32'h1, {31'h0, load_done_o});
    bus(1'b0, 12'h014, 32'h0);
    chk("loaded", 32'h44, rd);
    $display("test loader done");
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk("row", rows[i].e, rd);
    end
    for (int n = 0; n < 4; n++) begin
      drv = {slow_slew_o[n], deemphasis_level_o[n*4+:4], output_swing_o[n*3+:3]};
      chk("drive", rows[4+n].e, {24'h0, drv});
    end
    chk("boost", 32'hE4, {24'h0, eq_boost_o[23:16]});
    chk("adapt", 32'h0, {24'h0, eq_boost_o[7:0]});
    // a write while the clock enable is low must be lost
    enable_i <= 1'b0;
    bus(1'b1, 12'h004, 32'h5A);
    enable_i <= 1'b1;
    bus(1'b0, 12'h004, 32'h0);
    chk("frozen", 32'hA5, rd);
    $display("test table done");
    sig_on[1] <= 1'b0;
    repeat (5) @(posedge clock_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    bus(1'b0, 12'h104, 32'h0);
    chk("status", 32'h1, {31'h0, rd[1]});
    bus(1'b0, 12'h10C, 32'h0);
    chk("event", 32'h1, {31'h0, rd[1]});
    bus(1'b1, 12'h108, 32'hFF);
    repeat (3) @(posedge clock_i);
    chk("masked", 32'h0, {31'h0, irq_o});
    bus(1'b1, 12'h108, 32'h0);
    bus(1'b1, 12'h104, 32'hFF);
    bus(1'b0, 12'h104, 32'h0);
    chk("cleared", 32'h0, rd);
    chk("irq", 32'h0, {31'h0, irq_o});
    $display("test interrupt done");
    // target 64 edges per window: only the top code comes near it
    bus(1'b1, 12'h008, 32'h40);
    // let channel 3 leave its first trial before restarting it
    repeat (700) @(posedge clock_i);
    cdr_reset_i <= 4'h9;
    @(posedge clock_i);
    cdr_reset_i <= 4'h0;
    repeat (3) @(posedge clock_i);
    chk("lock3", 32'h0, {31'h0, lock_o[3]});
    chk("restart3", 32'h0, {27'h0, coarse_o[19:15]});
    bus(1'b0, 12'h03C, 32'h0);
    chk("busy3", 32'h1, {31'h0, rd[8]});
    $display("test recalibration done");
    repeat (20600) @(posedge clock_i);
    chk("coarse0", 32'h1F, {27'h0, coarse_o[4:0]});
    chk("lock0", 32'h1, {31'h0, lock_o[0]});
    bus(1'b0, 12'h00C, 32'h0);
    chk("stat0", 32'h001F0001, rd);
    bus(1'b1, 12'h100, 32'h0);
    cdr_reset_i[0] <= 1'b1;
    @(posedge clock_i);
    cdr_reset_i[0] <= 1'b0;
    repeat (3) @(posedge clock_i);
    bus(1'b0, 12'h00C, 32'h0);
    chk("noref", 32'h001F0001, rd);
    $display("test search done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    bus(1'b0, 12'h004, 32'h0);
    chk("drvreset", 32'h0, rd);
    chk("done", 32'h0, {31'h0, load_done_o});
    $display("test second reset done");
    stop_test();
  end
endmodule : tb_top
